// [tmpsc_timer.sv]
// 8-bit timer/counter with overflow flag and shared prescaler
//
// Operation
// - count wrapping from FFh to 00h sets the overflow flag.
// - cleared overflow_irq_enable (bit 5) masks the request; the flag still records.
// - timer stops counting during sleep, so it cannot overflow or wake.
// - pin path sampled on phase two and four; no prescaler means raw pin.
// - prescaler serves timer or watchdog, never both; the other runs unprescaled.
// - prescaler count cannot be read or written by software.
// - any timer count write clears the prescaler while it belongs to timer.
// - watchdog clear resets prescaler while it belongs to the watchdog.
// - timer count write leaves the prescaler assignment bit unchanged.
// - source select bit 5: one counts pin transitions, zero instruction cycles.
// - edge select bit 4: one falling edge, zero rising edge.
// - assignment bit 3: one gives prescaler to watchdog, zero to timer.
// - rate field divides timer by 2^(code+1), watchdog by 2^code.
// - every config bit resets to one, prescaler on watchdog at maximum ratio.
// - internal mode without prescaler advances the count every instruction cycle.
// - after a count write, counting is held off for two instruction cycles.
`timescale 1ns/1ps
module tmpsc_timer (
  // clock and reset
  input  wire logic       CLK_SYS_I,
  input  wire logic       RESET_N_I,
  // register port
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // core status
  input  wire logic       SLEEP_I,
  input  wire logic       WDT_CLEAR_I,
  // count pin and watchdog time base
  input  wire logic       EXT_COUNT_I,
  input  wire logic       WDT_TICK_I,
  output logic            WDT_TICK_O,
  // interrupt request
  output logic            IRQ_O
);

  tmpsc_pkg::tmpsc_phase_e phase;
  tmpsc_pkg::tmpsc_phase_e next_phase;

  logic [7:0] count;
  logic [7:0] option;
  logic       irq_en;
  logic       flag;
  logic [1:0] inhibit;
  logic       ext_meta;
  logic       ext_sync;
  logic       ext_lvl_d;
  logic       psc_sample;

  // decode
  logic       cnt_wr;
  logic       int_wr;
  logic       opt_wr;
  logic       phase_two;
  logic       phase_four;
  logic       insn_en;
  logic       src_ext;
  logic       edge_fall;
  logic       prescaler_assign;
  logic [2:0] rate;

  // counting path
  logic       ext_lvl;
  logic       ext_edge;
  logic       psc_evt;
  logic       psc_clr;
  logic [3:0] psc_exp;
  logic [7:0] psc_cnt;
  logic       psc_wrap;
  logic       psc_out;
  logic       ext_tick;
  logic       int_tick;
  logic       cnt_inc;
  logic       ovf_set;
  logic       wdt_tick;
  logic [7:0] rd_mux;
  logic       next_flag;

  // register decode
  assign cnt_wr  = WR_I & (ADDR_I == tmpsc_pkg::ADDR_COUNT);
  assign int_wr  = WR_I & (ADDR_I == tmpsc_pkg::ADDR_INTCTL);
  assign opt_wr  = WR_I & (ADDR_I == tmpsc_pkg::ADDR_OPTION);

  assign src_ext   = option[tmpsc_pkg::OPT_SRC_BIT];
  assign edge_fall = option[tmpsc_pkg::OPT_EDGE_BIT];
  assign prescaler_assign       = option[tmpsc_pkg::OPT_PSA_BIT];
  assign rate      = option[tmpsc_pkg::OPT_RATE_MSB:tmpsc_pkg::OPT_RATE_LSB];

  // phase clocks
  assign phase_two  = (phase == tmpsc_pkg::PH_TWO);
  assign phase_four = (phase == tmpsc_pkg::PH_FOUR);
  assign insn_en    = phase_four;

  always_comb begin
    unique case (phase)
      tmpsc_pkg::PH_ONE:   next_phase = tmpsc_pkg::PH_TWO;
      tmpsc_pkg::PH_TWO:   next_phase = tmpsc_pkg::PH_THREE;
      tmpsc_pkg::PH_THREE: next_phase = tmpsc_pkg::PH_FOUR;
      tmpsc_pkg::PH_FOUR:  next_phase = tmpsc_pkg::PH_ONE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      phase <= tmpsc_pkg::PH_ONE;
    end else begin
      phase <= next_phase;
    end
  end

  // pin synchroniser; the edge select inverts after the second stage
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      ext_meta <= EXT_COUNT_I;
      ext_sync <= ext_meta;
    end
  end

  assign ext_lvl  = ext_sync ^ edge_fall;
  assign ext_edge = ext_lvl & ~ext_lvl_d;

  // one prescaler, steered to watchdog or timer
  assign psc_evt = prescaler_assign ? WDT_TICK_I
                       : (~SLEEP_I & (src_ext ? ext_edge : insn_en));
  assign psc_clr = (cnt_wr & ~prescaler_assign) | (WDT_CLEAR_I & prescaler_assign);
  assign psc_exp = prescaler_assign ? {1'b0, rate} : ({1'b0, rate} + 4'h1);

  // prescaler count has no register address at all
  tmpsc_prescaler u_prescaler (
    .clk_i     (CLK_SYS_I),
    .reset_n_i (RESET_N_I),
    .clear_i   (psc_clr),
    .event_i   (psc_evt),
    .exp_i     (psc_exp),
    .count_o   (psc_cnt),
    .wrap_o    (psc_wrap)
  );

  // bit rate of the count is the divided level; raw pin when unassigned
  assign psc_out = prescaler_assign ? ext_lvl : psc_cnt[rate];

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      // idle pin with falling-edge reset config reads high: no false edge after reset
      ext_lvl_d  <= 1'b1;
      psc_sample <= 1'b1;
    end else begin
      ext_lvl_d <= ext_lvl;
      if (phase_two | phase_four) begin
        psc_sample <= psc_out;
      end
    end
  end

  // sampling twice per instruction needs the pin steady two periods each way
  assign ext_tick = (phase_two | phase_four) & psc_out & ~psc_sample;
  assign int_tick = prescaler_assign ? insn_en : psc_wrap;

  // sleep and the post-write hold both gate the increment
  assign cnt_inc = ~SLEEP_I & (inhibit == 2'h0)
                 & (src_ext ? ext_tick : int_tick);
  assign ovf_set = cnt_inc & (count == tmpsc_pkg::COUNT_MAX);

  // watchdog time base
  assign wdt_tick = prescaler_assign ? psc_wrap : WDT_TICK_I;

  // set wins over a software clear in the same cycle
  assign next_flag = ovf_set | (int_wr ? WDATA_I[tmpsc_pkg::INTCTL_FLAG_BIT] : flag);

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      count <= tmpsc_pkg::COUNT_RESET;
    end else if (cnt_wr) begin
      count <= WDATA_I;
    end else if (cnt_inc) begin
      count <= count + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      inhibit <= 2'h0;
    end else if (cnt_wr) begin
      inhibit <= tmpsc_pkg::INHIBIT_INSN;
    end else if (insn_en && inhibit != 2'h0) begin
      inhibit <= inhibit - 2'h1;
    end
  end

  // flag is only ever cleared by a software write
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      flag   <= 1'b0;
      irq_en <= 1'b0;
    end else begin
      flag <= next_flag;
      if (int_wr) begin
        irq_en <= WDATA_I[tmpsc_pkg::INTCTL_EN_BIT];
      end
    end
  end

  // only a config write moves the assignment bit
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      option <= tmpsc_pkg::OPTION_RESET;
    end else if (opt_wr) begin
      option <= WDATA_I;
    end
  end

  // read mux; unmapped addresses read zero
  assign rd_mux =
    (ADDR_I == tmpsc_pkg::ADDR_COUNT)  ? count :
    (ADDR_I == tmpsc_pkg::ADDR_OPTION) ? option :
    (ADDR_I == tmpsc_pkg::ADDR_INTCTL) ?
      (8'(irq_en) << tmpsc_pkg::INTCTL_EN_BIT) |
      (8'(flag) << tmpsc_pkg::INTCTL_FLAG_BIT) :
    tmpsc_pkg::READ_IDLE;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RDATA_O    <= tmpsc_pkg::READ_IDLE;
      WDT_TICK_O <= 1'b0;
      IRQ_O      <= 1'b0;
    end else begin
      RDATA_O    <= RD_I ? rd_mux : tmpsc_pkg::READ_IDLE;
      WDT_TICK_O <= wdt_tick;
      IRQ_O      <= flag & irq_en;
    end
  end

  // checks
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);

  property p_ovf_flag;
    cnt_inc && !cnt_wr && count == 8'hFF |=> count == 8'h00 && flag;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not set flag");

  property p_irq_mask;
    !irq_en |=> !IRQ_O;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request raised");

  property p_flag_held;
    flag && !int_wr |=> flag;
  endproperty
  a_flag_held: assert property (p_flag_held) else $error("flag cleared by hardware");

  property p_sleep_hold;
    SLEEP_I && !cnt_wr |=> $stable(count);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

  property p_wdt_raw;
    !prescaler_assign |=> WDT_TICK_O == $past(WDT_TICK_I);
  endproperty
  a_wdt_raw: assert property (p_wdt_raw) else $error("watchdog not unprescaled");

  property p_psc_clr_wr;
    cnt_wr && !prescaler_assign |=> psc_cnt == 8'h00;
  endproperty
  a_psc_clr_wr: assert property (p_psc_clr_wr) else $error("prescaler kept on write");

  property p_psc_clr_wdt;
    WDT_CLEAR_I && prescaler_assign |=> psc_cnt == 8'h00;
  endproperty
  a_psc_clr_wdt: assert property (p_psc_clr_wdt) else $error("prescaler kept on clear");

  property p_psa_keep;
    cnt_wr |=> prescaler_assign == $past(prescaler_assign);
  endproperty
  a_psa_keep: assert property (p_psa_keep) else $error("assignment changed");

  property p_inhibit;
    cnt_wr ##1 (!cnt_wr)[*8] |-> count == $past(count, 7);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("count moved in hold-off");

  property p_write_prio;
    cnt_wr |=> count == $past(WDATA_I);
  endproperty
  a_write_prio: assert property (p_write_prio) else $error("write lost");

  property p_int_rate;
    !src_ext && prescaler_assign && !SLEEP_I && inhibit == 2'h0 && insn_en && !cnt_wr
      |=> count == $past(count) + 8'h01;
  endproperty
  a_int_rate: assert property (p_int_rate) else $error("no step per cycle");

  property p_unmapped;
    RD_I && ADDR_I != tmpsc_pkg::ADDR_COUNT && ADDR_I != tmpsc_pkg::ADDR_OPTION
      && ADDR_I != tmpsc_pkg::ADDR_INTCTL |=> RDATA_O == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hidden state readable");

  c_overflow: cover property (ovf_set);
  c_ext_tick: cover property (src_ext && cnt_inc);
  c_wdt_clear: cover property (WDT_CLEAR_I && prescaler_assign);
  c_wr_ovf: cover property (cnt_wr && ovf_set);

endmodule // tmpsc_timer

// [tmpsc_pkg.sv]
// constants for the timer with shared prescaler
package tmpsc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_COUNT  = 8'h01;
  localparam logic [7:0] ADDR_INTCTL = 8'h0B;
  localparam logic [7:0] ADDR_OPTION = 8'h81;

  // interrupt_control fields
  localparam int INTCTL_EN_BIT   = 5;
  localparam int INTCTL_FLAG_BIT = 2;

  // timer_prescaler_config fields
  localparam int OPT_SRC_BIT   = 5;
  localparam int OPT_EDGE_BIT  = 4;
  localparam int OPT_PSA_BIT   = 3;
  localparam int OPT_RATE_MSB  = 2;
  localparam int OPT_RATE_LSB  = 0;

  // reset values and count limit
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] READ_IDLE    = 8'h00;

  // timing: one oscillator period per clock, four phases per instruction
  localparam int         TOSC_NS         = 20;
  localparam int         CLK_NS          = 20;
  localparam int         TOSC_CYCLES     = (TOSC_NS + CLK_NS - 1) / CLK_NS;
  localparam int         PHASES_PER_INSN = 4 * TOSC_CYCLES;
  localparam logic [1:0] INHIBIT_INSN    = 2'h2;

  // internal phase clocks, gray coded
  typedef enum logic [1:0] {
    PH_ONE   = 2'h0,
    PH_TWO   = 2'h1,
    PH_THREE = 2'h3,
    PH_FOUR  = 2'h2
  } tmpsc_phase_e;

endpackage

// [tmpsc_prescaler.sv]
// shared 8-bit prescaler counter, hidden from software
`timescale 1ns/1ps
module tmpsc_prescaler (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // control
  input  wire logic       clear_i,
  input  wire logic       event_i,
  input  wire logic [3:0] exp_i,
  // state
  output logic      [7:0] count_o,
  output logic            wrap_o
);

  logic [7:0] count;
  logic [7:0] mask;

  // low exp_i bits all set means this event completes the ratio
  assign mask    = ~(8'hFF << exp_i);
  assign wrap_o  = event_i & (&(count | ~mask));
  assign count_o = count;

  // clear wins over a coincident event
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= 8'h00;
    end else if (clear_i) begin
      count <= 8'h00;
    end else if (event_i) begin
      count <= count + 8'h01;
    end
  end

endmodule // tmpsc_prescaler

// [tmpsc_count_src.sv]
// count pulse source standing on the external count pin
`timescale 1ns/1ps
module tmpsc_count_src (
  // clock
  input  wire logic       clk_i,
  // request
  input  wire logic       go_i,
  input  wire logic [7:0] num_i,
  input  wire logic [7:0] half_i,
  // pin and status
  output logic            pin_o,
  output logic            busy_o
);
  initial begin
    pin_o  = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        busy_o <= 1'b1;
        // each level held half_i clocks, callers keep it at two or more
        repeat (num_i) begin
          pin_o <= 1'b1;
          repeat (half_i) @(posedge clk_i);
          pin_o <= 1'b0;
          repeat (half_i) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule // tmpsc_count_src

// [tmpsc_timer_tb_top.sv]
// self-checking bench for the timer with shared prescaler
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tmpsc_timer_tb_top;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       sleep = 1'b0;
  logic       wclr  = 1'b0;
  logic       wtick = 1'b0;
  logic       go    = 1'b0;
  logic [7:0] num   = 8'h00;
  logic [7:0] half  = 8'h03;
  logic [7:0] lfsr  = 8'h38;
  logic       pin;
  logic       busy;
  logic [7:0] rdata;
  logic       wtick_o;
  logic       irq;
  logic [7:0] v;
  logic [7:0] d;
  logic [2:0] r;
  int         failures    = 0;
  int         check_count = 0;
  int         wseen       = 0;
  time        t0;
  time        t1;

  tmpsc_timer i_dut (
    .CLK_SYS_I   (clk),
    .RESET_N_I   (rst_n),
    .ADDR_I      (addr),
    .WDATA_I     (wdata),
    .WR_I        (wr),
    .RD_I        (rd),
    .RDATA_O     (rdata),
    .SLEEP_I     (sleep),
    .WDT_CLEAR_I (wclr),
    .EXT_COUNT_I (pin),
    .WDT_TICK_I  (wtick),
    .WDT_TICK_O  (wtick_o),
    .IRQ_O       (irq)
  );
  tmpsc_count_src i_src (
    .clk_i  (clk),
    .go_i   (go),
    .num_i  (num),
    .half_i (half),
    .pin_o  (pin),
    .busy_o (busy)
  );

  always #10 clk = ~clk;
  always @(posedge clk) if (wtick_o === 1'b1) wseen++;

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // one count every 2^(code+1) instruction cycles of four clocks
  function automatic time step_ns(input logic [2:0] code);
    return time'(80) << (code + 1);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    addr  <= a;
    wdata <= x;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 x = rdata;
  endtask
  task automatic pulse(input logic [7:0] n, input logic [7:0] h);
    @(posedge clk);
    num  <= n;
    half <= h;
    go   <= 1'b1;
    @(posedge clk);
    go   <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      cyc(1);
      wtick <= 1'b1;
      cyc(1);
      wtick <= 1'b0;
    end
  endtask
  task automatic wdt_clr();
    cyc(1);
    wclr <= 1'b1;
    cyc(1);
    wclr <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait for the request line high or the pin source idle
  task automatic wait_on(input bit use_irq);
    int k;
    k = 0;
    #1;
    while ((use_irq ? irq !== 1'b1 : busy !== 1'b0) && k < 500) begin
      @(posedge clk);
      k++;
    end
    if (use_irq ? irq !== 1'b1 : busy !== 1'b0) begin
      failures++;
      end_sim();
    end
  endtask

  initial begin
    cyc(2);
    rst_n <= 1'b1;
    rd_reg(tmpsc_pkg::ADDR_OPTION, v);
    `CHK(v, tmpsc_pkg::OPTION_RESET)
    rd_reg(8'h55, v);
    `CHK(v, tmpsc_pkg::READ_IDLE)
    $display("test reset done");
    wr_reg(tmpsc_pkg::ADDR_OPTION, 8'h08);
    wr_reg(tmpsc_pkg::ADDR_INTCTL, 8'h20);
    wr_reg(tmpsc_pkg::ADDR_COUNT, 8'hFD);
    cyc(5);
    rd_reg(tmpsc_pkg::ADDR_COUNT, v);
    `CHK(v, 8'hFD)
    cyc(4);
    rd_reg(tmpsc_pkg::ADDR_COUNT, v);
    cyc(6);
    rd_reg(tmpsc_pkg::ADDR_COUNT, d);
    `CHK(d, 8'(v + 8'h02))
    wait_on(1'b1);
    rd_reg(tmpsc_pkg::ADDR_INTCTL, v);
    `CHK(v, 8'h24)
    wr_reg(tmpsc_pkg::ADDR_INTCTL, 8'h20);
    cyc(2);
    `CHK(irq, 1'b0)
    wr_reg(tmpsc_pkg::ADDR_INTCTL, 8'h00);
    wr_reg(tmpsc_pkg::ADDR_COUNT, 8'hFE);
    cyc(30);
    rd_reg(tmpsc_pkg::ADDR_INTCTL, v);
    `CHK(v, 8'h04)
    `CHK(irq, 1'b0)
    wr_reg(tmpsc_pkg::ADDR_INTCTL, 8'h00);
    cyc(1);
    sleep <= 1'b1;
    lfsr = nxt(lfsr);
    wr_reg(tmpsc_pkg::ADDR_COUNT, lfsr);
    cyc(40);
    rd_reg(tmpsc_pkg::ADDR_COUNT, v);
    `CHK(v, lfsr)
    sleep <= 1'b0;
    $display("test internal done");
    wdt_clr();
    for (int i = 0; i < 3; i++) begin
      r = 3'(i);
      wr_reg(tmpsc_pkg::ADDR_OPTION, {5'h00, r});
      lfsr = nxt(lfsr);
      wr_reg(tmpsc_pkg::ADDR_COUNT, lfsr);
      rd_reg(tmpsc_pkg::ADDR_OPTION, v);
      `CHK(v, {5'h00, r})
      v  = lfsr;
      t0 = 0;
      t1 = 0;
      for (int k = 0; k < 400 && t1 == 0; k++) begin
        rd_reg(tmpsc_pkg::ADDR_COUNT, d);
        if (d !== v) begin
          if (t0 == 0) t0 = $time;
          else t1 = $time;
          v = d;
        end
      end
      `CHK(t1 - t0, step_ns(r))
    end
    $display("test rate done");
    for (int e = 0; e < 2; e++) begin
      wr_reg(tmpsc_pkg::ADDR_OPTION, {3'b001, e[0], 4'h8});
      wr_reg(tmpsc_pkg::ADDR_COUNT, 8'h00);
      cyc(10);
      pulse(8'h01, 8'h14);
      cyc(12);
      rd_reg(tmpsc_pkg::ADDR_COUNT, v);
      `CHK(v, {7'h00, ~e[0]})
      wait_on(1'b0);
      cyc(10);
      rd_reg(tmpsc_pkg::ADDR_COUNT, v);
      `CHK(v, 8'h01)
    end
    lfsr = nxt(lfsr);
    r = {2'b00, lfsr[0]};
    wr_reg(tmpsc_pkg::ADDR_OPTION, {5'h04, r});
    wr_reg(tmpsc_pkg::ADDR_COUNT, 8'h00);
    cyc(10);
    pulse(8'(3 << (r + 1)), 8'h03);
    wait_on(1'b0);
    cyc(10);
    rd_reg(tmpsc_pkg::ADDR_COUNT, v);
    `CHK(v, 8'h03)
    $display("test external done");
    lfsr = nxt(lfsr);
    r = {1'b0, lfsr[1:0]};
    wr_reg(tmpsc_pkg::ADDR_OPTION, 8'h01);
    wr_reg(tmpsc_pkg::ADDR_COUNT, 8'h00);
    wr_reg(tmpsc_pkg::ADDR_OPTION, 8'h09);
    wdt_clr();
    wr_reg(tmpsc_pkg::ADDR_OPTION, {5'h01, r});
    cyc(3);
    wseen = 0;
    tick(3 << r);
    cyc(3);
    `CHK(wseen, 3)
    wdt_clr();
    wr_reg(tmpsc_pkg::ADDR_OPTION, 8'h00);
    cyc(3);
    wseen = 0;
    tick(4);
    cyc(3);
    `CHK(wseen, 4)
    $display("test watchdog done");
    end_sim();
  end
endmodule // tmpsc_timer_tb_top
